// ---- common/sps_map.svh ----
// Offsets, fields and timing constants of the power-up sequencer.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
// Own register offsets (byte addresses)
`define SPS_OFF_CTRL    8'h00
`define SPS_OFF_STATUS  8'h04
`define SPS_OFF_UCNT    8'h08
`define SPS_OFF_UTAB    8'h40
// Control fields
`define SPS_CTRL_RUN    0
`define SPS_CTRL_HRST   1
// Status fields
`define SPS_ST_CE       4
`define SPS_ST_DONE     5
`define SPS_ST_ERR      6
// Device registers and values
`define SPS_DEV_FILT    8'h16
`define SPS_DEV_PSEL    8'h40
`define SPS_DEV_POFS    8'h41
`define SPS_DEV_PVAL    8'h42
`define SPS_DEV_LPLL    8'h5b
`define SPS_FILT_VAL    8'h02
`define SPS_LPLL_BIT    5
`define SPS_SEL_HDMI    8'h10
`define SPS_SEL_LINK    8'h14
`define SPS_OFS_VAL     8'h49
`define SPS_PVAL_SET    8'h10
`define SPS_PVAL_CLR    8'h00
// Step count of sequence A; last step index of sequence B
`define SPS_A_STEPS     3'h3
`define SPS_B_STEPS     3'h7
// Timing
`define SPS_CLK_NS      8
`define SPS_CLK_KHZ     125000
`define SPS_RDY_MS      2
`define SPS_HRST_MS     2
`define SPS_CLKQ_NS     1000
`endif

// ---- common/sps_pkg.sv ----
// Types of the serializer power-up sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package sps_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_PWR   = 4'b0001,
    ST_BUSW  = 4'b0010,
    ST_SEQA  = 4'b0011,
    ST_USRA  = 4'b0100,
    ST_CLKW  = 4'b0101,
    ST_SEQB  = 4'b0110,
    ST_USRB  = 4'b0111,
    ST_DONE  = 4'b1000,
    ST_HRST  = 4'b1001,
    ST_ERR   = 4'b1010
  } sps_state_e;
endpackage

// ---- hdl/sps_sequencer.sv ----
// Host-side power-up and init sequencer for the serializer bridge.
// Assumes an outside bus master that performs single-register device
// accesses on the op_* handshake, and a clock monitor for HDMI.
//
// Summary of operation
// R1 - Raise chip enable only after supplies stable
// R2 - Drive no device input before supplies settle
// R3 - HDMI input enabled only after chip enable
// R4 - No bus access until 2 ms after enable
// R5 - Hard reset: enable low at least 2 ms; shorter if issued in ST_BUSW or ST_CLKW, whose cnt carries on into ST_HRST
// R6 - Sequence A clears link PLL auto-reset bit
// R7 - Sequence A writes 0x02 to filter register
// R8 - User writes may follow each sequence
// R9 - Sequence B only after HDMI clock stable
// R10 - HDMI PLL reset by four indexed writes
// R11 - Link PLL reset same writes, select 0x14
// R12 - Clock stable at least 1 us first
// R13 - Hold GPIO lines until enable released
// R14 - One access at a time, A before B
`timescale 1ns/100ps
`include "sps_map.svh"

module sps_sequencer #(
  parameter int RDY_CYC  = `SPS_RDY_MS * `SPS_CLK_KHZ,
  parameter int HRST_CYC = `SPS_HRST_MS * `SPS_CLK_KHZ,
  parameter int CW       = 18
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Software register port
  input  wire logic [7:0]  cpu_addr,
  input  wire logic [31:0] cpu_wdata,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  output logic      [31:0] cpu_rdata,
  // System status
  input  wire logic        supplies_stable,
  input  wire logic        hdmi_clk_stable,
  // Device pins
  output logic             chip_enable_input,
  output logic             gpio_hold,
  output logic             hdmi_in_enable,
  // Device register access
  output logic             op_req,
  output logic             op_read,
  output logic      [7:0]  op_reg,
  output logic      [7:0]  op_wdata,
  input  wire logic        op_ack,
  input  wire logic        op_nack,
  input  wire logic [7:0]  op_rdata
);

  localparam int CLKQ_CYC = (`SPS_CLKQ_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS;

  sps_pkg::sps_state_e state;
  logic [CW-1:0]       cnt;
  logic [2:0]          step;
  logic [4:0]          uidx;
  logic [3:0]          cnt_a;
  logic [3:0]          cnt_b;
  logic [15:0]         utab [16];
  logic                run;
  logic                hrst_cmd;
  logic                done;
  logic                err;
  logic [7:0]          lpll_val;
  logic [15:0]         b_ent;
  logic [4:0]          a_end;
  logic [4:0]          b_end;
  logic                wr_ctrl;

  assign wr_ctrl = cpu_wr && (cpu_addr == `SPS_OFF_CTRL);
  assign a_end   = {1'b0, cnt_a};
  assign b_end   = 5'({1'b0, cnt_a} + {1'b0, cnt_b});

  // Fixed PLL reset list: first four HDMI, last four link
  always_comb begin
    b_ent = {`SPS_DEV_PVAL, `SPS_PVAL_CLR};
    case (step[1:0])
      2'h0: b_ent = {`SPS_DEV_PSEL, step[2] ? `SPS_SEL_LINK : `SPS_SEL_HDMI}; // R10 R11
      2'h1: b_ent = {`SPS_DEV_POFS, `SPS_OFS_VAL};
      2'h2: b_ent = {`SPS_DEV_PVAL, `SPS_PVAL_SET};
      default: b_ent = {`SPS_DEV_PVAL, `SPS_PVAL_CLR};
    endcase
  end

  // Control register and user count writes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      run      <= 1'b0;
      hrst_cmd <= 1'b0;
      cnt_a    <= 4'h0;
      cnt_b    <= 4'h0;
    end else begin
      hrst_cmd <= wr_ctrl && cpu_wdata[`SPS_CTRL_HRST];
      if (wr_ctrl) begin
        run <= cpu_wdata[`SPS_CTRL_RUN];
      end
      if (cpu_wr && cpu_addr == `SPS_OFF_UCNT) begin
        cnt_a <= cpu_wdata[3:0];
        cnt_b <= cpu_wdata[7:4];
      end
    end
  end

  // User table; no reset, software fills it before use
  always_ff @(posedge sys_clk) begin
    if (cpu_wr && cpu_addr[7:6] == 2'(`SPS_OFF_UTAB >> 6) && cpu_addr[1:0] == 2'h0) begin
      utab[cpu_addr[5:2]] <= cpu_wdata[15:0];
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cpu_rdata <= 32'h0;
    end else if (cpu_rd) begin
      cpu_rdata <= 32'h0;
      if (cpu_addr == `SPS_OFF_CTRL) begin
        cpu_rdata[`SPS_CTRL_RUN] <= run;
      end else if (cpu_addr == `SPS_OFF_STATUS) begin
        cpu_rdata[3:0]          <= state;
        cpu_rdata[`SPS_ST_CE]   <= chip_enable_input;
        cpu_rdata[`SPS_ST_DONE] <= done;
        cpu_rdata[`SPS_ST_ERR]  <= err;
      end else if (cpu_addr == `SPS_OFF_UCNT) begin
        cpu_rdata[7:0] <= {cnt_b, cnt_a};
      end else if (cpu_addr[7:6] == 2'(`SPS_OFF_UTAB >> 6) && cpu_addr[1:0] == 2'h0) begin
        cpu_rdata[15:0] <= utab[cpu_addr[5:2]];
      end
    end
  end

  // Pins follow the state; enable is a flop output, never an RC delay
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      chip_enable_input <= 1'b0;
      gpio_hold         <= 1'b1;
      hdmi_in_enable    <= 1'b0;
    end else begin
      chip_enable_input <= (state != sps_pkg::ST_IDLE) && (state != sps_pkg::ST_HRST)
                           && (state != sps_pkg::ST_PWR || supplies_stable); // R1 R2 R5
      gpio_hold         <= !chip_enable_input; // R13
      hdmi_in_enable    <= chip_enable_input; // R3
    end
  end

  // Time base shared by enable delay, reset pulse and clock qualify
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt <= '0;
    end else if (state == sps_pkg::ST_CLKW && !hdmi_clk_stable) begin
      cnt <= '0; // R12
    end else if (state == sps_pkg::ST_BUSW || state == sps_pkg::ST_HRST
                 || state == sps_pkg::ST_CLKW) begin
      cnt <= cnt + 1'b1;
    end else begin
      cnt <= '0;
    end
  end

  // Sequencing and device access handshake
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state    <= sps_pkg::ST_IDLE;
      step     <= 3'h0;
      uidx     <= 5'h0;
      op_req   <= 1'b0;
      op_read  <= 1'b0;
      op_reg   <= 8'h0;
      op_wdata <= 8'h0;
      lpll_val <= 8'h0;
      done     <= 1'b0;
      err      <= 1'b0;
    end else if (hrst_cmd) begin
      // Abandons any access in flight; the pulse resets the device anyway
      state  <= sps_pkg::ST_HRST;
      op_req <= 1'b0;
      done   <= 1'b0;
    end else if (!run) begin
      state  <= sps_pkg::ST_IDLE;
      op_req <= 1'b0;
      done   <= 1'b0;
    end else begin
      case (state)
        sps_pkg::ST_IDLE: begin
          err   <= 1'b0;
          state <= sps_pkg::ST_PWR;
        end
        sps_pkg::ST_PWR: begin
          if (supplies_stable) begin
            state <= sps_pkg::ST_BUSW; // R1
          end
        end
        sps_pkg::ST_BUSW: begin
          if (cnt >= CW'(RDY_CYC - 1)) begin
            state <= sps_pkg::ST_SEQA; // R4
            step  <= 3'h0;
          end
        end
        sps_pkg::ST_HRST: begin
          if (cnt >= CW'(HRST_CYC - 1)) begin
            state <= sps_pkg::ST_PWR; // R5
          end
        end
        sps_pkg::ST_SEQA: begin
          if (!op_req) begin
            op_req <= 1'b1; // R14
            case (step)
              3'h0: begin
                op_read <= 1'b1;
                op_reg  <= `SPS_DEV_LPLL;
              end
              3'h1: begin
                op_read  <= 1'b0;
                op_reg   <= `SPS_DEV_LPLL;
                op_wdata <= lpll_val; // R6
              end
              default: begin
                op_read  <= 1'b0;
                op_reg   <= `SPS_DEV_FILT;
                op_wdata <= `SPS_FILT_VAL; // R7
              end
            endcase
          end else if (op_nack) begin
            op_req <= 1'b0;
            err    <= 1'b1;
            state  <= sps_pkg::ST_ERR;
          end else if (op_ack) begin
            op_req <= 1'b0;
            if (step == 3'h0) begin
              lpll_val <= op_rdata & ~(8'h1 << `SPS_LPLL_BIT); // R6
            end
            step <= step + 3'h1;
            if (step == `SPS_A_STEPS - 3'h1) begin
              state <= sps_pkg::ST_USRA;
              uidx  <= 5'h0;
            end
          end
        end
        sps_pkg::ST_USRA, sps_pkg::ST_USRB: begin
          if (!op_req) begin
            if (uidx == (state == sps_pkg::ST_USRA ? a_end : b_end)) begin
              state <= (state == sps_pkg::ST_USRA) ? sps_pkg::ST_CLKW
                                                   : sps_pkg::ST_DONE; // R8 R14
              step  <= 3'h0;
            end else begin
              op_req   <= 1'b1;
              op_read  <= 1'b0;
              op_reg   <= utab[uidx[3:0]][15:8]; // R8
              op_wdata <= utab[uidx[3:0]][7:0];
            end
          end else if (op_nack) begin
            op_req <= 1'b0;
            err    <= 1'b1;
            state  <= sps_pkg::ST_ERR;
          end else if (op_ack) begin
            op_req <= 1'b0;
            uidx   <= uidx + 5'h1;
          end
        end
        sps_pkg::ST_CLKW: begin
          if (hdmi_clk_stable && cnt >= CW'(CLKQ_CYC - 1)) begin
            state <= sps_pkg::ST_SEQB; // R9 R12
            step  <= 3'h0;
          end
        end
        sps_pkg::ST_SEQB: begin
          if (!op_req) begin
            op_req   <= 1'b1; // R14
            op_read  <= 1'b0;
            op_reg   <= b_ent[15:8]; // R10 R11
            op_wdata <= b_ent[7:0];
          end else if (op_nack) begin
            op_req <= 1'b0;
            err    <= 1'b1;
            state  <= sps_pkg::ST_ERR;
          end else if (op_ack) begin
            op_req <= 1'b0;
            step   <= step + 3'h1;
            if (step == `SPS_B_STEPS) begin
              state <= sps_pkg::ST_USRB;
              uidx  <= a_end;
            end
          end
        end
        sps_pkg::ST_DONE: begin
          done <= 1'b1;
        end
        sps_pkg::ST_ERR: begin
          err <= 1'b1;
        end
        default: begin
          state <= sps_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- testbench/sps_props.sv ----
// Checker for the sequencer ports: pin order, waits, access rules.
// Assumes one clock domain; bound into the sequencer below.
`timescale 1ns/100ps
module sps_props #(
  parameter int RDY_CYC  = 250000,
  parameter int HRST_CYC = 250000,
  parameter int CW       = 18
) (
  // Clock, reset and status inputs
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       supplies_stable,
  input wire logic       hdmi_clk_stable,
  // Pins and device access
  input wire logic       chip_enable_input,
  input wire logic       gpio_hold,
  input wire logic       hdmi_in_enable,
  input wire logic       op_req,
  input wire logic       op_read,
  input wire logic [7:0] op_reg,
  input wire logic [7:0] op_wdata,
  input wire logic       op_ack,
  input wire logic       op_nack
);
  int up_cnt;
  int low_cnt;
  int clk_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Run lengths; low count starts full so a cold start passes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      up_cnt  <= 0;
      low_cnt <= HRST_CYC;
      clk_cnt <= 0;
    end else begin
      up_cnt  <= chip_enable_input ? up_cnt + 1 : 0;
      low_cnt <= chip_enable_input ? 0 : low_cnt + 1;
      clk_cnt <= hdmi_clk_stable ? clk_cnt + 1 : 0;
    end
  end
  sequence s_beat;
    op_req && (op_ack || op_nack);
  endsequence
  sequence s_wr(r);
    op_req && !op_read && op_reg == r;
  endsequence
  a_bus_ready_wait: assert property ($rose(op_req) |-> up_cnt >= RDY_CYC)
    else $error("access before bus ready time");
  a_enable_after_supply: assert property ($rose(chip_enable_input) |-> $past(supplies_stable))
    else $error("enable raised before supplies stable");
  a_hard_reset_width: assert property ($rose(chip_enable_input) |-> low_cnt >= HRST_CYC)
    else $error("enable low pulse too short");
  a_hdmi_after_enable: assert property (hdmi_in_enable |-> $past(chip_enable_input))
    else $error("hdmi enabled before chip enable");
  a_gpio_held_low: assert property (!chip_enable_input |=> gpio_hold)
    else $error("gpio released while enable low");
  a_req_fields_held: assert property (op_req && !op_ack && !op_nack |=>
    !op_req || $stable({op_read, op_reg, op_wdata}))
    else $error("access fields changed while pending");
  a_one_gap: assert property (s_beat |=> !op_req)
    else $error("no idle cycle after answer");
  a_link_bit_clear: assert property (s_wr(8'h5b) |-> !op_wdata[5])
    else $error("link pll auto reset bit not cleared");
  a_filter_value: assert property (s_wr(8'h16) |-> op_wdata == 8'h02)
    else $error("filter register value wrong");
  a_clock_hold_first: assert property (s_wr(8'h40) |-> clk_cnt >= 125)
    else $error("pll reset before clock stable");
  a_offset_value: assert property (s_wr(8'h41) |-> op_wdata == 8'h49)
    else $error("pll offset value wrong");
endmodule
bind sps_sequencer sps_props #(.RDY_CYC(RDY_CYC), .HRST_CYC(HRST_CYC), .CW(CW)) u_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .supplies_stable(supplies_stable),
  .hdmi_clk_stable(hdmi_clk_stable), .chip_enable_input(chip_enable_input),
  .gpio_hold(gpio_hold), .hdmi_in_enable(hdmi_in_enable), .op_req(op_req),
  .op_read(op_read), .op_reg(op_reg), .op_wdata(op_wdata), .op_ack(op_ack),
  .op_nack(op_nack));

// ---- testbench/sps_dev_model.sv ----
// Device model: register file behind the op_* access port.
// Assumes single accesses from the sequencer on the same clock.
`timescale 1ns/100ps
module sps_dev_model #(
  parameter int RDY = 50
) (
  // Clock and enable pin
  input  wire logic       sys_clk,
  input  wire logic       chip_enable_input,
  // Access port
  input  wire logic       op_req,
  input  wire logic       op_read,
  input  wire logic [7:0] op_reg,
  input  wire logic [7:0] op_wdata,
  output logic            op_ack = 1'b0,
  output logic            op_nack = 1'b0,
  output logic      [7:0] op_rdata = 8'h3c
);
  logic [7:0]  mem [256];
  logic [15:0] log_q [$];
  int          up = 0;
  int          wt = 0;
  // Enable low restarts the ready count; link pll byte set arbitrarily
  always @(posedge sys_clk) begin
    up <= chip_enable_input ? up + 1 : 0;
    if (!chip_enable_input) mem[8'h5b] <= 8'hff;
  end
  // Prompt or slow answer by parity of the logged write count; data toggles when idle
  always @(posedge sys_clk) begin
    op_ack   <= 1'b0;
    op_nack  <= 1'b0;
    op_rdata <= ~op_rdata;
    wt       <= 0;
    if (op_req && !op_ack && !op_nack && chip_enable_input) begin
      wt <= wt + 1;
      if (wt == log_q.size() % 2 * 3) begin
        wt      <= 0;
        op_nack <= up < RDY || op_reg == 8'hee;
        op_ack  <= up >= RDY && op_reg != 8'hee; // Register ee is refused
        if (op_read) begin
          op_rdata <= mem[op_reg];
        end else if (up >= RDY && op_reg != 8'hee) begin
          mem[op_reg] <= op_wdata;
          log_q.push_back({op_reg, op_wdata});
        end
      end
    end
  end
endmodule

// ---- testbench/sps_sequencer_bench.sv ----
// Bench for the power-up sequencer: bus tasks, device model, checks.
// Assumes the checker file is compiled alongside.
`timescale 1ns/100ps
`include "sps_map.svh"
module sps_sequencer_bench;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  cpu_addr = 8'h00;
  logic [31:0] cpu_wdata = 32'h0;
  logic        cpu_wr = 1'b0;
  logic        cpu_rd = 1'b0;
  logic        sup_ok = 1'b0;
  logic        clk_ok = 1'b0;
  logic [31:0] cpu_rdata, v;
  logic        ce, gpio_hold, hdmi_en, op_req, op_read, op_ack, op_nack;
  logic [7:0]  op_reg, op_wdata, op_rdata;
  int          err_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [15:0] exp_w [12] = '{16'h5bdf, 16'h1602, 16'h30a5, 16'h4010, 16'h4149,
    16'h4210, 16'h4200, 16'h4014, 16'h4149, 16'h4210, 16'h4200, 16'h315a};
  sps_sequencer #(.RDY_CYC(50), .HRST_CYC(50), .CW(18)) dut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .supplies_stable(sup_ok),
    .hdmi_clk_stable(clk_ok), .chip_enable_input(ce), .gpio_hold(gpio_hold),
    .hdmi_in_enable(hdmi_en), .op_req(op_req), .op_read(op_read), .op_reg(op_reg),
    .op_wdata(op_wdata), .op_ack(op_ack), .op_nack(op_nack), .op_rdata(op_rdata));
  sps_dev_model #(.RDY(50)) dev (.sys_clk(sys_clk), .chip_enable_input(ce),
    .op_req(op_req), .op_read(op_read), .op_reg(op_reg), .op_wdata(op_wdata),
    .op_ack(op_ack), .op_nack(op_nack), .op_rdata(op_rdata));
  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard, well above the 1200 or so cycles needed
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cpu_addr  <= a;
    cpu_wdata <= d;
    cpu_wr    <= 1'b1;
    @(posedge sys_clk);
    cpu_wr    <= 1'b0;
  endtask
  // Data appears in the cycle after the strobe and holds until the next read
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    cpu_addr <= a;
    cpu_rd   <= 1'b1;
    @(posedge sys_clk);
    cpu_rd   <= 1'b0;
    #1;
    v = cpu_rdata;
  endtask
  task automatic wait_log(input int n);
    repeat (3000) if (dev.log_q.size() < n) @(posedge sys_clk);
  endtask
  task automatic chk_log(input int b);
    for (int i = 0; i < 12; i++) chk("write", dev.log_q[b + i], exp_w[i]);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(`SPS_OFF_STATUS);
    chk("status", v, 32'h0);
    chk("gpio", gpio_hold, 1'b1);
    wr(8'h30, 32'h1);
    rd(8'h30);
    chk("unmapped", v, 32'h0);
    wr(`SPS_OFF_UTAB, 32'h30a5);
    wr(`SPS_OFF_UTAB + 8'h04, 32'h315a);
    wr(`SPS_OFF_UCNT, 32'h11);
    wr(`SPS_OFF_CTRL, 32'h1);
    repeat (20) @(posedge sys_clk);
    chk("ce", ce, 1'b0);
    chk("hdmi", hdmi_en, 1'b0);
    $display("test reset done");
    sup_ok <= 1'b1;
    wait_log(3);
    repeat (200) @(posedge sys_clk);
    chk("a count", dev.log_q.size(), 3);
    rd(`SPS_OFF_STATUS);
    chk("clk wait", v, 32'h15);
    clk_ok <= 1'b1;
    repeat (60) @(posedge sys_clk);
    clk_ok <= 1'b0;
    @(posedge sys_clk);
    chk("early b", dev.log_q.size(), 3);
    clk_ok <= 1'b1;
    wait_log(12);
    repeat (20) @(posedge sys_clk);
    chk_log(0);
    rd(`SPS_OFF_STATUS);
    chk("done", v, 32'h38);
    $display("test init done");
    wr(`SPS_OFF_CTRL, 32'h3);
    repeat (3) @(posedge sys_clk);
    chk("ce low", ce, 1'b0);
    repeat (40) @(posedge sys_clk);
    chk("ce held", ce, 1'b0);
    rd(`SPS_OFF_CTRL);
    chk("ctrl", v, 32'h1);
    wait_log(24);
    chk_log(12);
    $display("test hard reset done");
    // Refused access halts the run; enable kept low long enough first
    wr(`SPS_OFF_CTRL, 32'h0);
    repeat (60) @(posedge sys_clk);
    wr(`SPS_OFF_UTAB + 8'h04, 32'hee00);
    wr(`SPS_OFF_CTRL, 32'h1);
    wait_log(35);
    repeat (40) @(posedge sys_clk);
    chk("nack stop", dev.log_q.size(), 35);
    rd(`SPS_OFF_STATUS);
    chk("error", v, 32'h5a);
    $display("test refused access done");
    complete_run();
  end
endmodule
